// >>> cid_pkg.sv
// Package for the core instruction decoder: widths, opcodes, fields and timing
package cid_pkg;
  // Word and field widths
  localparam int INSTR_W = 14;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  // Oscillator clocks per instruction cycle
  localparam int Q_PER_CYCLE = 4;
  localparam logic [1:0] Q_LAST = 2'(Q_PER_CYCLE - 1);
  localparam logic [1:0] Q_RESET = 2'h0;
  // Field positions inside the instruction word
  localparam int DEST_BIT = 7;
  localparam int BIT_POS_LSB = 7;
  localparam int BANK_LIT_W = 6;
  localparam int PC_LATCH_HIGH_LIT_W = 7;
  // Indirect access register offsets within a bank
  localparam logic [6:0] INDIRECT0_ADDR = 7'h00;
  localparam logic [6:0] INDIRECT1_ADDR = 7'h01;
  // Operand values that make increment or decrement skip, and the zero-flag value
  localparam logic [7:0] INC_WRAP_VAL = 8'hff;
  localparam logic [7:0] DEC_ONE_VAL = 8'h01;
  localparam logic [7:0] ZERO_VAL = 8'h00;
  // Cycle counts
  localparam logic [1:0] ONE_CYCLE = 2'h1;
  // Opcode patterns, ? marks operand or don't-care bits
  localparam logic [13:0] P_ADD_REG = 14'b00_0111_????_????;
  localparam logic [13:0] P_ADD_REG_CARRY = 14'b11_1101_????_????;
  localparam logic [13:0] P_AND_REG = 14'b00_0101_????_????;
  localparam logic [13:0] P_ASR = 14'b11_0111_????_????;
  localparam logic [13:0] P_LSL = 14'b11_0101_????_????;
  localparam logic [13:0] P_LSR = 14'b11_0110_????_????;
  localparam logic [13:0] P_CLEAR_ACC = 14'b00_0001_0000_00??;
  localparam logic [13:0] P_LOAD_BANK = 14'b00_0001_01??_????;
  localparam logic [13:0] P_CLEAR_REG = 14'b00_0001_1???_????;
  localparam logic [13:0] P_COMPLEMENT = 14'b00_1001_????_????;
  localparam logic [13:0] P_DECREMENT = 14'b00_0011_????_????;
  localparam logic [13:0] P_INCREMENT = 14'b00_1010_????_????;
  localparam logic [13:0] P_OR_REG = 14'b00_0100_????_????;
  localparam logic [13:0] P_MOVE_REG = 14'b00_1000_????_????;
  localparam logic [13:0] P_STORE_ACC = 14'b00_0000_1???_????;
  localparam logic [13:0] P_ROT_LEFT = 14'b00_1101_????_????;
  localparam logic [13:0] P_ROT_RIGHT = 14'b00_1100_????_????;
  localparam logic [13:0] P_SUB_REG = 14'b00_0010_????_????;
  localparam logic [13:0] P_SUB_REG_BORROW = 14'b11_1011_????_????;
  localparam logic [13:0] P_SWAP = 14'b00_1110_????_????;
  localparam logic [13:0] P_XOR_REG = 14'b00_0110_????_????;
  localparam logic [13:0] P_DEC_SKIP = 14'b00_1011_????_????;
  localparam logic [13:0] P_INC_SKIP = 14'b00_1111_????_????;
  localparam logic [13:0] P_BIT_CLEAR = 14'b01_00??_????_????;
  localparam logic [13:0] P_BIT_SET = 14'b01_01??_????_????;
  localparam logic [13:0] P_TEST_CLEAR = 14'b01_10??_????_????;
  localparam logic [13:0] P_TEST_SET = 14'b01_11??_????_????;
  localparam logic [13:0] P_ADD_LIT = 14'b11_1110_????_????;
  localparam logic [13:0] P_AND_LIT = 14'b11_1001_????_????;
  localparam logic [13:0] P_OR_LIT = 14'b11_1000_????_????;
  localparam logic [13:0] P_LOAD_PCLATCH = 14'b11_0001_1???_????;
  localparam logic [13:0] P_LOAD_ACC = 14'b11_0000_????_????;
  localparam logic [13:0] P_SUB_LIT = 14'b11_1100_????_????;
  localparam logic [13:0] P_XOR_LIT = 14'b11_1010_????_????;
  localparam logic [13:0] P_REL_BRANCH = 14'b11_001?_????_????;
  localparam logic [13:0] P_REL_BRANCH_ACC = 14'b00_0000_0000_1011;
  localparam logic [13:0] P_SUB_CALL = 14'b10_0???_????_????;
  localparam logic [13:0] P_SUB_CALL_ACC = 14'b00_0000_0000_1010;
  localparam logic [13:0] P_ABS_JUMP = 14'b10_1???_????_????;
  localparam logic [13:0] P_INT_RETURN = 14'b00_0000_0000_1001;
  localparam logic [13:0] P_RET_LITERAL = 14'b11_0100_????_????;
  localparam logic [13:0] P_SUB_RETURN = 14'b00_0000_0000_1000;

  // Decoded operations
  typedef enum logic [5:0] {
    OP_NONE, OP_ADD_REG, OP_ADD_REG_CARRY, OP_AND_REG, OP_ASR, OP_LSL, OP_LSR,
    OP_CLEAR_REG, OP_CLEAR_ACC, OP_COMPLEMENT, OP_DECREMENT, OP_INCREMENT,
    OP_OR_REG, OP_MOVE_REG, OP_STORE_ACC, OP_ROT_LEFT, OP_ROT_RIGHT, OP_SUB_REG,
    OP_SUB_REG_BORROW, OP_SWAP, OP_XOR_REG, OP_DEC_SKIP, OP_INC_SKIP,
    OP_BIT_CLEAR, OP_BIT_SET, OP_TEST_CLEAR, OP_TEST_SET, OP_ADD_LIT, OP_AND_LIT,
    OP_OR_LIT, OP_LOAD_BANK, OP_LOAD_PCLATCH, OP_LOAD_ACC, OP_SUB_LIT,
    OP_XOR_LIT, OP_REL_BRANCH, OP_REL_BRANCH_ACC, OP_SUB_CALL, OP_SUB_CALL_ACC,
    OP_ABS_JUMP, OP_INT_RETURN, OP_RET_LITERAL, OP_SUB_RETURN
  } cid_op_e;

  // Decoded instruction record
  typedef struct packed {
    cid_op_e op;
    logic dest_file;
    logic [6:0] file_addr;
    logic [2:0] bit_pos;
    logic [7:0] literal;
    logic ptr_sel;
    logic names_file;
    logic file_write;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    logic pc_change;
    logic cond_skip;
  } cid_dec_s;

  // Timing states
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_EXTRA, ST_NOP} cid_state_e;
endpackage : cid_pkg

// >>> cid_core_decoder.sv
// Instruction decoder and instruction-cycle timing for the 8-bit core
// Behaviour
// - Each instruction is one 14-bit word
// - Single cycle unless listed exceptions apply
// - Subroutine calls take two cycles
// - All returns take two cycles
// - Jumps, branches and taken skips take two
// - Indirect access into program memory adds cycle
// - Instruction cycle is four clock periods
// - File writes read the register first
// - Destination bit: 0 accumulator, 1 file
// - File address is low seven bits
// - Arithmetic ops update carry, digit carry, zero
// - Logic byte ops update zero only
// - Rotates set carry; shifts carry and zero
// - Don't-care encoding bits are ignored
// - Increment/decrement skip on zero, no flags
// - Bit clear/set use 3-bit position
// - Bit tests skip on match, no flags
// - Add/subtract literal update three flags
// - Literal logic ops update zero only
// - Literal moves leave flags alone
// - Pointer select bit picks pointer pair
// - Final cycle of a flow change or taken skip executes as nop
module cid_core_decoder import cid_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Program memory word
  input wire logic [13:0] instr_word,
  // Datapath feedback
  input wire logic [7:0] file_rd_data,
  input wire logic [7:0] alu_result,
  input wire logic [1:0] fsr_msb,
  // Decoded instruction
  output cid_dec_s dec_out,
  // Cycle timing
  output logic [1:0] q_phase,
  output logic cycle_end,
  output logic instr_take,
  output logic exec_cycle,
  output logic extra_cycle,
  output logic nop_cycle,
  output logic [1:0] instr_cycles,
  // Zero flag
  output logic zero_flag
);

  // Decode one word into a record
  function automatic cid_dec_s decode(input logic [13:0] w);
    cid_dec_s d;
    d = '0;
    d.op = OP_NONE;
    d.dest_file = w[DEST_BIT];
    d.file_addr = w[ADDR_W-1:0];
    d.bit_pos = w[BIT_POS_LSB +: 3];
    d.literal = w[DATA_W-1:0];
    d.ptr_sel = w[0];
    // Wildcard match ignores operand and don't-care bits
    casez (w)
      P_CLEAR_ACC: d.op = OP_CLEAR_ACC;
      P_REL_BRANCH_ACC: d.op = OP_REL_BRANCH_ACC;
      P_SUB_CALL_ACC: d.op = OP_SUB_CALL_ACC;
      P_INT_RETURN: d.op = OP_INT_RETURN;
      P_SUB_RETURN: d.op = OP_SUB_RETURN;
      P_LOAD_BANK: d.op = OP_LOAD_BANK;
      P_CLEAR_REG: d.op = OP_CLEAR_REG;
      P_STORE_ACC: d.op = OP_STORE_ACC;
      P_ADD_REG: d.op = OP_ADD_REG;
      P_ADD_REG_CARRY: d.op = OP_ADD_REG_CARRY;
      P_AND_REG: d.op = OP_AND_REG;
      P_ASR: d.op = OP_ASR;
      P_LSL: d.op = OP_LSL;
      P_LSR: d.op = OP_LSR;
      P_COMPLEMENT: d.op = OP_COMPLEMENT;
      P_DECREMENT: d.op = OP_DECREMENT;
      P_INCREMENT: d.op = OP_INCREMENT;
      P_OR_REG: d.op = OP_OR_REG;
      P_MOVE_REG: d.op = OP_MOVE_REG;
      P_ROT_LEFT: d.op = OP_ROT_LEFT;
      P_ROT_RIGHT: d.op = OP_ROT_RIGHT;
      P_SUB_REG: d.op = OP_SUB_REG;
      P_SUB_REG_BORROW: d.op = OP_SUB_REG_BORROW;
      P_SWAP: d.op = OP_SWAP;
      P_XOR_REG: d.op = OP_XOR_REG;
      P_DEC_SKIP: d.op = OP_DEC_SKIP;
      P_INC_SKIP: d.op = OP_INC_SKIP;
      P_BIT_CLEAR: d.op = OP_BIT_CLEAR;
      P_BIT_SET: d.op = OP_BIT_SET;
      P_TEST_CLEAR: d.op = OP_TEST_CLEAR;
      P_TEST_SET: d.op = OP_TEST_SET;
      P_ADD_LIT: d.op = OP_ADD_LIT;
      P_AND_LIT: d.op = OP_AND_LIT;
      P_OR_LIT: d.op = OP_OR_LIT;
      P_LOAD_PCLATCH: d.op = OP_LOAD_PCLATCH;
      P_LOAD_ACC: d.op = OP_LOAD_ACC;
      P_SUB_LIT: d.op = OP_SUB_LIT;
      P_XOR_LIT: d.op = OP_XOR_LIT;
      P_REL_BRANCH: d.op = OP_REL_BRANCH;
      P_SUB_CALL: d.op = OP_SUB_CALL;
      P_ABS_JUMP: d.op = OP_ABS_JUMP;
      P_RET_LITERAL: d.op = OP_RET_LITERAL;
      default: d.op = OP_NONE;
    endcase
    // Literal widths narrower than a byte
    if (d.op == OP_LOAD_BANK) begin
      d.literal = {2'h0, w[BANK_LIT_W-1:0]};
    end else if (d.op == OP_LOAD_PCLATCH) begin
      d.literal = {1'h0, w[PC_LATCH_HIGH_LIT_W-1:0]};
    end
    // Flags, file access and flow per operation
    case (d.op)
      OP_ADD_REG, OP_ADD_REG_CARRY, OP_SUB_REG, OP_SUB_REG_BORROW: begin
        d.upd_c = 1'b1;
        d.upd_dc = 1'b1;
        d.upd_z = 1'b1;
      end
      OP_ADD_LIT, OP_SUB_LIT: begin
        d.upd_c = 1'b1;
        d.upd_dc = 1'b1;
        d.upd_z = 1'b1;
      end
      OP_AND_REG, OP_OR_REG, OP_XOR_REG, OP_COMPLEMENT, OP_INCREMENT,
      OP_DECREMENT, OP_MOVE_REG, OP_CLEAR_REG, OP_CLEAR_ACC: begin
        d.upd_z = 1'b1;
      end
      OP_AND_LIT, OP_OR_LIT, OP_XOR_LIT: begin
        d.upd_z = 1'b1;
      end
      OP_ROT_LEFT, OP_ROT_RIGHT: begin
        d.upd_c = 1'b1;
      end
      OP_ASR, OP_LSL, OP_LSR: begin
        d.upd_c = 1'b1;
        d.upd_z = 1'b1;
      end
      OP_SUB_CALL, OP_SUB_CALL_ACC: d.pc_change = 1'b1;
      OP_SUB_RETURN, OP_RET_LITERAL, OP_INT_RETURN: d.pc_change = 1'b1;
      OP_ABS_JUMP, OP_REL_BRANCH, OP_REL_BRANCH_ACC: d.pc_change = 1'b1;
      default: d.upd_z = 1'b0;
    endcase
    // Skip operations are conditional two-cycle
    d.cond_skip = (d.op == OP_DEC_SKIP) || (d.op == OP_INC_SKIP) ||
                  (d.op == OP_TEST_CLEAR) || (d.op == OP_TEST_SET);
    // Every file-named op reads its register first
    d.names_file = (w[13:12] == 2'h1) || d.op inside {OP_ADD_REG,
      OP_ADD_REG_CARRY, OP_AND_REG, OP_ASR, OP_LSL, OP_LSR, OP_CLEAR_REG,
      OP_COMPLEMENT, OP_DECREMENT, OP_INCREMENT, OP_OR_REG, OP_MOVE_REG,
      OP_STORE_ACC, OP_ROT_LEFT, OP_ROT_RIGHT, OP_SUB_REG, OP_SUB_REG_BORROW,
      OP_SWAP, OP_XOR_REG, OP_DEC_SKIP, OP_INC_SKIP};
    // Write back to the file register
    if (d.op inside {OP_CLEAR_REG, OP_STORE_ACC, OP_BIT_CLEAR, OP_BIT_SET}) begin
      d.file_write = 1'b1;
    end else if (d.op inside {OP_TEST_CLEAR, OP_TEST_SET}) begin
      d.file_write = 1'b0;
    end else begin
      d.file_write = d.names_file & d.dest_file;
    end
    return d;
  endfunction : decode

  // Registered state
  logic [1:0] phase_reg, phase_next; // Oscillator phase in the cycle
  cid_state_e state_reg, state_next; // Cycle kind
  cid_dec_s dec_reg, dec_next; // Current instruction
  logic cycle_end_reg, cycle_end_next; // Last phase marker
  logic take_reg, take_next; // Word taken pulse
  logic [1:0] count_reg, count_next; // Cycles used so far
  logic [1:0] cycles_reg, cycles_next; // Cycles of last instruction
  logic zero_reg, zero_next; // Zero flag
  logic exec_reg, exec_next; // Execute cycle flag
  logic extra_reg, extra_next; // Extra indirect cycle flag
  logic nop_reg, nop_next; // No-operation cycle flag

  // Combinational helpers
  logic at_end; // Final phase of this cycle
  logic extra_need; // Indirect access into program memory
  logic skip_hit; // Skip condition met
  logic last_data; // Cycle that finishes the data part
  logic tested_bit; // Selected file bit

  // Per-cycle conditions
  always_comb begin
    at_end = (phase_reg == Q_LAST);
    tested_bit = file_rd_data[dec_reg.bit_pos];
    // Pointer MSb set means program memory
    extra_need = dec_reg.names_file &&
                 (((dec_reg.file_addr == INDIRECT0_ADDR) && fsr_msb[0]) ||
                  ((dec_reg.file_addr == INDIRECT1_ADDR) && fsr_msb[1]));
    // Skip outcome from the value read
    case (dec_reg.op)
      OP_DEC_SKIP: skip_hit = (file_rd_data == DEC_ONE_VAL);
      OP_INC_SKIP: skip_hit = (file_rd_data == INC_WRAP_VAL);
      OP_TEST_CLEAR: skip_hit = !tested_bit;
      OP_TEST_SET: skip_hit = tested_bit;
      default: skip_hit = 1'b0;
    endcase
    last_data = ((state_reg == ST_EXEC) && !extra_need) || (state_reg == ST_EXTRA);
  end

  // Next state of phase, sequencing and flags
  always_comb begin
    // Phase counter wraps every four clocks
    phase_next = phase_reg + 2'h1;
    state_next = state_reg;
    dec_next = dec_reg;
    take_next = 1'b0;
    count_next = count_reg;
    cycles_next = cycles_reg;
    zero_next = zero_reg;
    if (at_end) begin
      phase_next = Q_RESET;
      // Zero flag from the finished result
      if (last_data && dec_reg.upd_z) begin
        zero_next = (alu_result == ZERO_VAL);
      end
      // Pick the kind of the next instruction cycle
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_EXEC;
        end
        ST_EXEC: begin
          if (extra_need) begin
            state_next = ST_EXTRA;
          end else if (dec_reg.pc_change || skip_hit) begin
            state_next = ST_NOP;
          end else begin
            state_next = ST_EXEC;
          end
        end
        ST_EXTRA: begin
          if (dec_reg.pc_change || skip_hit) begin
            state_next = ST_NOP;
          end else begin
            state_next = ST_EXEC;
          end
        end
        default: begin
          state_next = ST_EXEC;
        end
      endcase
      // Take a new word when the next cycle executes
      if (state_next == ST_EXEC) begin
        dec_next = decode(instr_word);
        take_next = 1'b1;
        count_next = ONE_CYCLE;
        // Nothing has finished yet on the first cycle after reset
        if (state_reg != ST_IDLE) begin
          cycles_next = count_reg;
        end
      end else begin
        // One more cycle spent on this instruction
        count_next = count_reg + 2'h1;
      end
    end
    cycle_end_next = (phase_next == Q_LAST);
    // Cycle kind flags registered so the outputs come from flops
    exec_next = (state_next == ST_EXEC);
    extra_next = (state_next == ST_EXTRA);
    nop_next = (state_next == ST_NOP);
  end

  // Register all state
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_reg <= Q_RESET;
      state_reg <= ST_IDLE;
      dec_reg <= '0;
      cycle_end_reg <= 1'b0;
      take_reg <= 1'b0;
      count_reg <= 2'h0;
      cycles_reg <= 2'h0;
      zero_reg <= 1'b0;
      exec_reg <= 1'b0;
      extra_reg <= 1'b0;
      nop_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      state_reg <= state_next;
      dec_reg <= dec_next;
      cycle_end_reg <= cycle_end_next;
      take_reg <= take_next;
      count_reg <= count_next;
      cycles_reg <= cycles_next;
      zero_reg <= zero_next;
      exec_reg <= exec_next;
      extra_reg <= extra_next;
      nop_reg <= nop_next;
    end
  end

  // Outputs straight from flip-flops
  assign dec_out = dec_reg;
  assign q_phase = phase_reg;
  assign cycle_end = cycle_end_reg;
  assign instr_take = take_reg;
  assign exec_cycle = exec_reg;
  assign extra_cycle = extra_reg;
  assign nop_cycle = nop_reg;
  assign instr_cycles = cycles_reg;
  assign zero_flag = zero_reg;

endmodule : cid_core_decoder

// >>> cid_core_decoder_properties.sv
// Port-level timing and field checks for the core instruction decoder
module cid_core_decoder_properties import cid_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Decoder inputs
  input wire logic [13:0] instr_word,
  input wire logic [7:0] file_rd_data,
  input wire logic [7:0] alu_result,
  input wire logic [1:0] fsr_msb,
  // Decoder outputs
  input wire cid_dec_s dec_out,
  input wire logic [1:0] q_phase,
  input wire logic cycle_end,
  input wire logic instr_take,
  input wire logic exec_cycle,
  input wire logic extra_cycle,
  input wire logic nop_cycle,
  input wire logic [1:0] instr_cycles,
  input wire logic zero_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // Single clock domain for every check
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // Indirect register reached through a pointer into program memory
  logic ind_hit;
  assign ind_hit = dec_out.names_file && fsr_msb[dec_out.ptr_sel] &&
    (dec_out.file_addr == INDIRECT0_ADDR || dec_out.file_addr == INDIRECT1_ADDR);
  // Phase steps by one per clock and wraps after four
  phase_step_a: assert property (q_phase != Q_LAST |=> q_phase == $past(q_phase) + 2'h1)
    else $error("phase did not step by one");
  phase_wrap_a: assert property (q_phase == Q_LAST |=> q_phase == Q_RESET)
    else $error("phase did not wrap to zero");
  end_marker_a: assert property (cycle_end == (q_phase == Q_LAST))
    else $error("cycle end not in last phase");
  // A take opens an execute cycle and is not repeated within it
  take_spacing_a: assert property (instr_take |->
    (q_phase == Q_RESET && exec_cycle) ##1 !instr_take [*3])
    else $error("take not aligned or repeated");
  state_excl_a: assert property ($onehot0({exec_cycle, extra_cycle, nop_cycle}))
    else $error("more than one cycle state");
  // Flow change is followed by exactly one nop cycle
  flow_nop_a: assert property (
    exec_cycle && cycle_end && dec_out.pc_change |=>
    (nop_cycle && !instr_take) [*4] ##1 instr_take)
    else $error("flow change not two cycles");
  indirect_extra_a: assert property (
    exec_cycle && cycle_end && ind_hit |=> extra_cycle [*4])
    else $error("indirect access lacks extra cycle");
  single_cycle_a: assert property (
    exec_cycle && cycle_end && !ind_hit && !dec_out.pc_change && !dec_out.cond_skip |=>
    instr_take) else $error("plain instruction not one cycle");
  field_map_a: assert property (instr_take && dec_out.names_file |->
    {dec_out.dest_file, dec_out.file_addr} == 8'($past(instr_word)))
    else $error("file address or destination wrong");
  skip_flags_a: assert property (
    dec_out.cond_skip |-> !(dec_out.upd_c || dec_out.upd_dc || dec_out.upd_z))
    else $error("skip instruction updates flags");
  rmw_read_a: assert property (dec_out.file_write |-> dec_out.names_file)
    else $error("file write without file read");
endmodule : cid_core_decoder_properties

// >>> cid_prog_mem.sv
// Program memory model handing one instruction word at a time to the decoder
module cid_prog_mem import cid_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Decoder handshake
  input wire logic instr_take,
  output logic [13:0] instr_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // Stored program, filled by the bench
  logic [13:0] rom [64];
  logic [5:0] ptr_reg;
  logic [5:0] ptr_next;
  // Move on once the decoder has taken the current word
  always_comb begin
    ptr_next = instr_take ? ptr_reg + 6'h1 : ptr_reg;
  end
  // Register the pointer
  always_ff @(posedge clk) begin
    ptr_reg <= srst ? 6'h00 : ptr_next;
  end
  // Whole word with opcode and operands
  assign instr_word = rom[ptr_reg];
endmodule : cid_prog_mem

// >>> cid_core_decoder_tb.sv
// Self-checking bench for the core instruction decoder
module cid_core_decoder_tb import cid_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  // One program entry with its datapath value and expectations
  typedef struct packed {
    logic [13:0] w;
    logic [7:0] v;
    logic [1:0] file_select_pointer;
    cid_op_e op;
    logic [2:0] fl;
    logic [1:0] k;
    logic [1:0] cyc;
  } cid_tb_ent_s;
  // Design signals
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [13:0] instr_word;
  logic [7:0] file_rd_data = 8'h00;
  logic [7:0] alu_result = 8'h00;
  logic [1:0] fsr_msb = 2'h0;
  cid_dec_s dec_out;
  logic [1:0] q_phase;
  logic [1:0] instr_cycles;
  logic cycle_end, instr_take, exec_cycle, extra_cycle, nop_cycle, zero_flag;
  // Bench state
  int n_fail = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  cid_tb_ent_s prog[$];
  logic exp_z = 1'b0;
  logic [1:0] prev_cyc = 2'h0;
  // 20 MHz clock
  always #25 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      n_fail++;
      test_done();
    end
  end
  cid_core_decoder dut_u (
    .clk(clk), .srst(srst), .instr_word(instr_word), .file_rd_data(file_rd_data),
    .alu_result(alu_result), .fsr_msb(fsr_msb), .dec_out(dec_out), .q_phase(q_phase),
    .cycle_end(cycle_end), .instr_take(instr_take), .exec_cycle(exec_cycle),
    .extra_cycle(extra_cycle), .nop_cycle(nop_cycle), .instr_cycles(instr_cycles),
    .zero_flag(zero_flag)
  );
  cid_prog_mem mem_u (.clk(clk), .srst(srst), .instr_take(instr_take), .instr_word(instr_word));
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  // Compare one value with its expectation
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Queue an entry: kf is kind and c, dc, z flags; vf is pointer bits and value
  task automatic ent(input logic [13:0] w, input cid_op_e op, input logic [4:0] kf,
    input logic [1:0] c, input logic [9:0] vf);
    prog.push_back('{w, vf[7:0], vf[9:8], op, kf[2:0], kf[4:3], c});
  endtask : ent
  // Wait for the next take, bounded, counting clocks
  task automatic wait_take(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (instr_take !== 1'b1 && n < 40);
  endtask : wait_take
  // Quiet outputs while reset is held
  task automatic chk_reset();
    check("rst_phase", q_phase, 2'h0);
    check("rst_op", dec_out.op, OP_NONE);
    check("rst_state", {exec_cycle, extra_cycle, nop_cycle, instr_take, cycle_end}, 5'h0);
    check("rst_cnt", {instr_cycles, zero_flag}, 3'h0);
  endtask : chk_reset
  // Execute one entry from its take to the next take
  task automatic step(input cid_tb_ent_s e);
    int n;
    check("cycles", instr_cycles, prev_cyc);
    check("zero", zero_flag, exp_z);
    check("op", dec_out.op, e.op);
    check("flags", {dec_out.upd_c, dec_out.upd_dc, dec_out.upd_z}, e.fl);
    check("names", dec_out.names_file, e.k inside {2'h1, 2'h2});
    check("write", dec_out.file_write, e.k == 2'h1 ? e.w[7] : e.k == 2'h2 && !e.w[11]);
    if (e.k inside {2'h1, 2'h2}) begin
      check("addr", dec_out.file_addr, e.w[6:0]);
      check("ptr", dec_out.ptr_sel, e.w[0]);
    end
    if (e.k == 2'h1) check("dest", dec_out.dest_file, e.w[7]);
    if (e.k == 2'h2) check("bit", dec_out.bit_pos, e.w[9:7]);
    if (e.k == 2'h3) check("lit", dec_out.literal, e.w[7:0]);
    if (e.op == OP_LOAD_BANK) check("bank", dec_out.literal, e.w[5:0]);
    if (e.op == OP_LOAD_PCLATCH) check("pclatch", dec_out.literal, e.w[6:0]);
    file_rd_data = e.v;
    alu_result = e.v;
    fsr_msb = e.file_select_pointer;
    if (e.fl[0]) exp_z = e.v == 8'h00;
    prev_cyc = e.cyc;
    wait_take(n);
    check("clocks", n, 4 * e.cyc);
  endtask : step
  // Main sequence
  initial begin
    int n;
    ent(14'h07a5, OP_ADD_REG, 5'h0f, 2'h1, 10'h000);
    ent(14'h3d7f, OP_ADD_REG_CARRY, 5'h0f, 2'h1, 10'h012);
    ent(14'h0280, OP_SUB_REG, 5'h0f, 2'h1, 10'h000);
    ent(14'h3b33, OP_SUB_REG_BORROW, 5'h0f, 2'h1, 10'h001);
    ent(14'h0581, OP_AND_REG, 5'h09, 2'h2, 10'h200);
    ent(14'h0400, OP_OR_REG, 5'h09, 2'h1, 10'h200);
    ent(14'h0610, OP_XOR_REG, 5'h09, 2'h1, 10'h355);
    ent(14'h0901, OP_COMPLEMENT, 5'h09, 2'h1, 10'h1ff);
    ent(14'h0a8a, OP_INCREMENT, 5'h09, 2'h1, 10'h000);
    ent(14'h0300, OP_DECREMENT, 5'h09, 2'h2, 10'h104);
    ent(14'h0808, OP_MOVE_REG, 5'h09, 2'h1, 10'h000);
    ent(14'h01c5, OP_CLEAR_REG, 5'h09, 2'h1, 10'h000);
    ent(14'h00c6, OP_STORE_ACC, 5'h08, 2'h1, 10'h000);
    ent(14'h0e47, OP_SWAP, 5'h08, 2'h1, 10'h000);
    ent(14'h0000, OP_NONE, 5'h00, 2'h1, 10'h000);
    ent(14'h0d11, OP_ROT_LEFT, 5'h0c, 2'h1, 10'h000);
    ent(14'h0c92, OP_ROT_RIGHT, 5'h0c, 2'h1, 10'h040);
    ent(14'h3713, OP_ASR, 5'h0d, 2'h1, 10'h0c0);
    ent(14'h3594, OP_LSL, 5'h0d, 2'h1, 10'h000);
    ent(14'h3615, OP_LSR, 5'h0d, 2'h1, 10'h080);
    ent(14'h0103, OP_CLEAR_ACC, 5'h01, 2'h1, 10'h000);
    ent(14'h0b96, OP_DEC_SKIP, 5'h08, 2'h2, 10'h001);
    ent(14'h0f17, OP_INC_SKIP, 5'h08, 2'h1, 10'h005);
    ent(14'h13a0, OP_BIT_CLEAR, 5'h10, 2'h1, 10'h0ff);
    ent(14'h1421, OP_BIT_SET, 5'h10, 2'h1, 10'h000);
    ent(14'h1981, OP_TEST_CLEAR, 5'h10, 2'h3, 10'h2f7);
    ent(14'h1ea2, OP_TEST_SET, 5'h10, 2'h1, 10'h0df);
    ent(14'h3eff, OP_ADD_LIT, 5'h1f, 2'h1, 10'h000);
    ent(14'h3c00, OP_SUB_LIT, 5'h1f, 2'h1, 10'h03c);
    ent(14'h39a5, OP_AND_LIT, 5'h19, 2'h1, 10'h000);
    ent(14'h385a, OP_OR_LIT, 5'h19, 2'h1, 10'h05a);
    ent(14'h3a0f, OP_XOR_LIT, 5'h19, 2'h1, 10'h000);
    ent(14'h3080, OP_LOAD_ACC, 5'h18, 2'h1, 10'h001);
    ent(14'h017f, OP_LOAD_BANK, 5'h00, 2'h1, 10'h000);
    ent(14'h31ff, OP_LOAD_PCLATCH, 5'h00, 2'h1, 10'h000);
    ent(14'h2123, OP_SUB_CALL, 5'h00, 2'h2, 10'h000);
    ent(14'h000a, OP_SUB_CALL_ACC, 5'h00, 2'h2, 10'h000);
    ent(14'h0008, OP_SUB_RETURN, 5'h00, 2'h2, 10'h000);
    ent(14'h3455, OP_RET_LITERAL, 5'h00, 2'h2, 10'h000);
    ent(14'h0009, OP_INT_RETURN, 5'h00, 2'h2, 10'h000);
    ent(14'h2fff, OP_ABS_JUMP, 5'h00, 2'h2, 10'h000);
    ent(14'h33ff, OP_REL_BRANCH, 5'h00, 2'h2, 10'h000);
    ent(14'h000b, OP_REL_BRANCH_ACC, 5'h00, 2'h2, 10'h000);
    for (int i = 0; i < 64; i++) begin
      mem_u.rom[i] = i < prog.size() ? prog[i].w : 14'h0000;
    end
    repeat (10) @(negedge clk);
    chk_reset();
    srst = 1'b0;
    $display("test reset done");
    wait_take(n);
    check("first_take", n, 16'h0004);
    foreach (prog[i]) begin
      step(prog[i]);
    end
    $display("test program done");
    srst = 1'b1;
    repeat (2) @(negedge clk);
    chk_reset();
    srst = 1'b0;
    wait_take(n);
    check("restart_take", n, 16'h0004);
    check("restart_op", dec_out.op, OP_ADD_REG);
    $display("test restart done");
    test_done();
  end
endmodule : cid_core_decoder_tb
// Attach the port checks to the decoder
bind cid_core_decoder cid_core_decoder_properties chk_u (.clk(clk), .srst(srst),
  .instr_word(instr_word), .file_rd_data(file_rd_data), .alu_result(alu_result),
  .fsr_msb(fsr_msb), .dec_out(dec_out), .q_phase(q_phase), .cycle_end(cycle_end),
  .instr_take(instr_take), .exec_cycle(exec_cycle), .extra_cycle(extra_cycle),
  .nop_cycle(nop_cycle), .instr_cycles(instr_cycles), .zero_flag(zero_flag));
